// >>> include/kpc_pkg.sv
// shared constants and types for the headset key resistance classifier
package kpc_pkg;
  // register port
  localparam int KPC_ADDR_W = 8;
  localparam int KPC_DATA_W = 8;
  localparam logic [KPC_ADDR_W-1:0] KPC_ADDR_BOUND_ONE = 8'h0d;
  localparam logic [KPC_ADDR_W-1:0] KPC_ADDR_BOUND_TWO = 8'h0e;
  localparam logic [KPC_ADDR_W-1:0] KPC_ADDR_BOUND_THREE = 8'h0f;
  // boundary field: bits 6..0, one code step is 6 ohm
  localparam int KPC_CODE_W = 7;
  localparam int KPC_OHM_PER_STEP = 6;
  localparam logic [KPC_CODE_W-1:0] KPC_BOUND_ONE_RST = 7'h10;
  localparam logic [KPC_CODE_W-1:0] KPC_BOUND_TWO_RST = 7'h20;
  localparam logic [KPC_CODE_W-1:0] KPC_BOUND_THREE_RST = 7'h34;
  localparam int KPC_KEYS = 4;
  // timing
  localparam int KPC_CLK_MHZ = 100;
  localparam int KPC_PRESS_DEB_MS = 30;
  localparam int KPC_REL_DEB_MS = 30;
  localparam int KPC_PRESS_DEB_CYC = KPC_PRESS_DEB_MS * 1000 * KPC_CLK_MHZ;
  localparam int KPC_REL_DEB_CYC = KPC_REL_DEB_MS * 1000 * KPC_CLK_MHZ;
  localparam int KPC_CNT_W = 24;

  typedef struct packed {
    logic [KPC_ADDR_W-1:0] addr;
    logic [KPC_DATA_W-1:0] wdata;
    logic wr;
  } kpc_reg_req_t;

  typedef struct packed {
    logic [KPC_KEYS-1:0] press;
    logic [KPC_KEYS-1:0] rel;
  } kpc_flags_t;
endpackage

// >>> design/kpc_debounce.sv
// level debouncer: one-cycle pulse once a level has held for a set number of cycles
`timescale 1ns/1ps
module kpc_debounce #(
  parameter int CYCLES = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic level_i,
  output logic done_o
);
  import kpc_pkg::*;

  localparam logic [KPC_CNT_W-1:0] LAST = KPC_CNT_W'(CYCLES - 1);

  logic [KPC_CNT_W-1:0] cnt;

  // any drop of the level restarts the wait, so glitches never accumulate
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
    end else if (!level_i) begin
      cnt <= '0;
    end else if (cnt != LAST) begin
      cnt <= cnt + KPC_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= level_i && (cnt == LAST) && !done_o;
    end
  end
endmodule

// >>> design/kpc_classifier.sv
// key press classifier: boundary registers, debounce, key bins and event flags
`timescale 1ns/1ps
// How it works
// - boundary one register at 0x0d
// - boundary two register at 0x0e
// - boundary three register at 0x0f
// - seven-bit field, six ohm per step
// - code picks key one to four
// - defaults cover the four standard bins
// - press accepted after debounced low level
// - press sets flag, clears release, interrupts
// - disable or removal clears all flags
module kpc_classifier #(
  parameter int PRESS_DEB_CYC = kpc_pkg::KPC_PRESS_DEB_CYC,
  parameter int REL_DEB_CYC = kpc_pkg::KPC_REL_DEB_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire kpc_pkg::kpc_reg_req_t reg_req_i,
  input wire logic [kpc_pkg::KPC_ADDR_W-1:0] reg_rd_addr_i,
  output logic [kpc_pkg::KPC_DATA_W-1:0] reg_rdata_o,
  input wire logic key_detect_enable_i,
  input wire logic accessory_removed_i,
  input wire logic mic_line_below_i,
  input wire logic [kpc_pkg::KPC_CODE_W-1:0] res_code_i,
  input wire logic event_clear_i,
  output kpc_pkg::kpc_flags_t flags_o,
  output logic irq_b_o
);
  import kpc_pkg::*;

  logic [KPC_CODE_W-1:0] bound_one;
  logic [KPC_CODE_W-1:0] bound_two;
  logic [KPC_CODE_W-1:0] bound_three;
  logic pressed;
  logic [KPC_KEYS-1:0] held_key;
  logic [KPC_KEYS-1:0] next_key;
  logic press_done;
  logic rel_done;
  logic flush;

  ////////////////////////////////////////////////////////////////////////////
  // boundary registers

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bound_one <= KPC_BOUND_ONE_RST;
      bound_two <= KPC_BOUND_TWO_RST;
      bound_three <= KPC_BOUND_THREE_RST;
    end else if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        KPC_ADDR_BOUND_ONE: begin
          bound_one <= reg_req_i.wdata[KPC_CODE_W-1:0];
        end
        KPC_ADDR_BOUND_TWO: begin
          bound_two <= reg_req_i.wdata[KPC_CODE_W-1:0];
        end
        KPC_ADDR_BOUND_THREE: begin
          bound_three <= reg_req_i.wdata[KPC_CODE_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // bit 7 and unmapped addresses read as zero
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else begin
      case (reg_rd_addr_i)
        KPC_ADDR_BOUND_ONE: reg_rdata_o <= {1'b0, bound_one};
        KPC_ADDR_BOUND_TWO: reg_rdata_o <= {1'b0, bound_two};
        KPC_ADDR_BOUND_THREE: reg_rdata_o <= {1'b0, bound_three};
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // classification; misordered boundaries simply give a wrong key

  always_comb begin
    next_key = '0;
    if (res_code_i < bound_one) begin
      next_key[0] = 1'b1;
    end else if (res_code_i < bound_two) begin
      next_key[1] = 1'b1;
    end else if (res_code_i < bound_three) begin
      next_key[2] = 1'b1;
    end else begin
      next_key[3] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debounce and press state

  // the release wait only runs while a key is held, so an idle line never reports a release
  assign flush = !key_detect_enable_i || accessory_removed_i;

  kpc_debounce #(
    .CYCLES(PRESS_DEB_CYC)
  ) u_press_deb (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .level_i(mic_line_below_i && !pressed && !flush),
    .done_o(press_done)
  );

  kpc_debounce #(
    .CYCLES(REL_DEB_CYC)
  ) u_rel_deb (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .level_i(!mic_line_below_i && pressed && !flush),
    .done_o(rel_done)
  );

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pressed <= 1'b0;
      held_key <= '0;
    end else if (flush) begin
      pressed <= 1'b0;
      held_key <= '0;
    end else if (press_done) begin
      pressed <= 1'b1;
      held_key <= next_key;
    end else if (rel_done) begin
      pressed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flags: a new event wins over a software clear, the flush wins over all

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_o <= '0;
    end else if (flush) begin
      flags_o <= '0;
    end else begin
      if (event_clear_i) begin
        flags_o <= '0;
      end
      if (press_done) begin
        flags_o.press <= (event_clear_i ? '0 : flags_o.press) | next_key;
        flags_o.rel <= (event_clear_i ? '0 : flags_o.rel) & ~next_key;
      end else if (rel_done) begin
        flags_o.press <= event_clear_i ? '0 : flags_o.press;
        flags_o.rel <= (event_clear_i ? '0 : flags_o.rel) | held_key;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_b_o <= 1'b1;
    end else begin
      irq_b_o <= ~(|flags_o);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_bound_one_write: assert property (
    reg_req_i.wr && reg_req_i.addr == KPC_ADDR_BOUND_ONE |=> bound_one == $past(reg_req_i.wdata[KPC_CODE_W-1:0]))
    else $error("boundary one write lost");
  chk_bound_two_write: assert property (
    reg_req_i.wr && reg_req_i.addr == KPC_ADDR_BOUND_TWO |=> bound_two == $past(reg_req_i.wdata[KPC_CODE_W-1:0]))
    else $error("boundary two write lost");
  chk_bound_three_read: assert property (
    reg_req_i.wr && reg_req_i.addr == KPC_ADDR_BOUND_THREE && reg_rd_addr_i == KPC_ADDR_BOUND_THREE
    ##1 reg_rd_addr_i == KPC_ADDR_BOUND_THREE
    |=> reg_rdata_o == {1'b0, $past(reg_req_i.wdata[KPC_CODE_W-1:0], 2)})
    else $error("boundary three readback wrong");
  chk_field_top_zero: assert property (
    reg_rdata_o[7] == 1'b0)
    else $error("reserved bit seen set");
  chk_key_bins: assert property (
    (res_code_i < bound_one) == next_key[0] && (res_code_i >= bound_three) == next_key[3])
    else $error("key bin wrong");
  chk_key_onehot: assert property (
    $onehot(next_key))
    else $error("more than one key picked");
  chk_edge_higher: assert property (
    res_code_i == bound_two && bound_one < bound_two && bound_two < bound_three |-> next_key[2])
    else $error("boundary code not given to higher key");
  chk_press_debounce: assert property (
    press_done |-> $past(mic_line_below_i) && !$past(pressed))
    else $error("press accepted without low level");
  chk_press_flags: assert property (
    press_done && !flush |=> (flags_o.press & held_key) == held_key && (flags_o.rel & held_key) == '0
    ##1 !irq_b_o)
    else $error("press flags or interrupt wrong");
  chk_clear_race: assert property (
    press_done && event_clear_i && !flush |=> flags_o.press == held_key && flags_o.rel == '0)
    else $error("event lost to software clear");
  chk_irq_follows: assert property (
    |flags_o |=> !irq_b_o)
    else $error("interrupt not raised for a pending flag");
  chk_flush_idle: assert property (
    flush |=> !pressed && held_key == '0)
    else $error("press state kept through disable");
  chk_flush_clears: assert property (
    flush |=> flags_o == '0 ##1 irq_b_o)
    else $error("flags not cleared on disable");

  cov_press: cover property (press_done ##[1:1000] rel_done);
  cov_clear_race: cover property (press_done && event_clear_i);
  cov_key_four: cover property (press_done && next_key[3]);
  cov_flush_held: cover property (pressed && flush);
endmodule

// >>> testbench/kpc_headset.sv
// headset key network model: mic line level and resistance code
`timescale 1ns/1ps
module kpc_headset (
  input wire logic sys_clk_i,
  input wire logic press_i,
  input wire logic [6:0] code_i,
  output logic below_o,
  output logic [6:0] code_o
);
  initial below_o = 1'b0;
  initial code_o = 7'h00;
  // with no key held the code means nothing, so it keeps toggling
  always @(posedge sys_clk_i) begin
    below_o <= press_i;
    code_o <= press_i ? code_i : ~code_o;
  end
endmodule

// >>> testbench/headset_key_resistance_classifier_tb.sv
// self-checking bench for the key resistance classifier
`timescale 1ns/1ps
module headset_key_resistance_classifier_tb;
  import kpc_pkg::*;
  localparam int DEB = 4;
  logic sys_clk_i;
  logic rst_b_i;
  kpc_reg_req_t req;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  logic en;
  logic gone;
  logic below;
  logic [6:0] rcode;
  logic clr;
  kpc_flags_t flags;
  logic irq_b;
  logic press;
  logic [6:0] pcode;
  logic [6:0] b1, b2, b3;
  logic [3:0] m;
  logic [6:0] cv [$];
  int err_total;
  int checked;
  kpc_classifier #(.PRESS_DEB_CYC(DEB), .REL_DEB_CYC(DEB)) kpc_classifier_i (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .reg_req_i(req), .reg_rd_addr_i(rd_addr), .reg_rdata_o(rdata), .key_detect_enable_i(en),
    .accessory_removed_i(gone), .mic_line_below_i(below), .res_code_i(rcode), .event_clear_i(clr),
    .flags_o(flags), .irq_b_o(irq_b));
  kpc_headset kpc_headset_i (.sys_clk_i(sys_clk_i), .press_i(press), .code_i(pcode), .below_o(below),
    .code_o(rcode));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////
  // equal to a boundary goes to the higher key
  function automatic logic [3:0] key_of(input logic [6:0] c);
    return (c < b1) ? 4'h1 : (c < b2) ? 4'h2 : (c < b3) ? 4'h4 : 4'h8;
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1};
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    rd_addr <= a;
    repeat (2) @(posedge sys_clk_i);
    #1 cmp("rdata", e, rdata);
  endtask
  task automatic step(input logic p, input logic [6:0] c, input logic [7:0] pre, input logic [7:0] e);
    @(posedge sys_clk_i);
    press <= p;
    pcode <= c;
    repeat (DEB + 1) @(posedge sys_clk_i);
    #1 cmp("flags early", pre, flags);
    repeat (3) @(posedge sys_clk_i);
    #1 cmp("flags", e, flags);
    cmp("irq", 8'h00, {7'h00, irq_b});
  endtask
  task automatic clear_all;
    @(posedge sys_clk_i);
    clr <= 1'b1;
    @(posedge sys_clk_i);
    clr <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 cmp("cleared", 8'h00, flags);
    cmp("irq idle", 8'h01, {7'h00, irq_b});
  endtask
  // software clear in the very cycle a press is accepted: the new press must survive
  task automatic race(input logic [6:0] c, input logic [7:0] e);
    @(posedge sys_clk_i);
    press <= 1'b1;
    pcode <= c;
    repeat (DEB + 1) @(posedge sys_clk_i);
    clr <= 1'b1;
    @(posedge sys_clk_i);
    clr <= 1'b0;
    #1 cmp("race", e, flags);
  endtask
  task automatic run;
    foreach (cv[i]) begin
      m = key_of(cv[i]);
      step(1'b1, cv[i], 8'h00, {m, 4'h0});
      step(1'b0, cv[i], {m, 4'h0}, {m, m});
      clear_all;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    err_total = 0;
    checked = 0;
    rst_b_i = 1'b0;
    req = '0;
    rd_addr = 8'h00;
    en = 1'b0;
    gone = 1'b0;
    clr = 1'b0;
    press = 1'b0;
    pcode = 7'h00;
    b1 = KPC_BOUND_ONE_RST;
    b2 = KPC_BOUND_TWO_RST;
    b3 = KPC_BOUND_THREE_RST;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd(KPC_ADDR_BOUND_ONE, {1'b0, b1});
    rd(KPC_ADDR_BOUND_TWO, {1'b0, b2});
    rd(KPC_ADDR_BOUND_THREE, {1'b0, b3});
    rd(8'h10, 8'h00);
    $display("test reset values done");
    @(posedge sys_clk_i);
    en <= 1'b1;
    cv = '{7'h0b, 7'h15, 7'h26, 7'h71, 7'h10, 7'h20, 7'h34};
    run;
    $display("test default bins done");
    wr(KPC_ADDR_BOUND_ONE, 8'h85);
    wr(KPC_ADDR_BOUND_TWO, 8'h0a);
    rd(KPC_ADDR_BOUND_THREE, {1'b0, b3});
    wr(KPC_ADDR_BOUND_THREE, 8'h0c);
    b1 = 7'h05;
    b2 = 7'h0a;
    b3 = 7'h0c;
    rd(KPC_ADDR_BOUND_ONE, 8'h05);
    rd(KPC_ADDR_BOUND_THREE, 8'h0c);
    cv = '{7'h04, 7'h05, 7'h0b, 7'h0c, 7'h7f};
    run;
    $display("test programmed bins done");
    step(1'b1, 7'h05, 8'h00, 8'h20);
    step(1'b0, 7'h05, 8'h20, 8'h22);
    step(1'b1, 7'h05, 8'h22, 8'h20);
    step(1'b0, 7'h05, 8'h20, 8'h22);
    race(7'h0c, 8'h80);
    @(posedge sys_clk_i);
    en <= 1'b0;
    press <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 cmp("flags off", 8'h00, flags);
    @(posedge sys_clk_i);
    en <= 1'b1;
    step(1'b1, 7'h00, 8'h00, 8'h10);
    @(posedge sys_clk_i);
    gone <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 cmp("flags removed", 8'h00, flags);
    $display("test flush done");
    wrap_up;
  end
endmodule
